/* hdl/otp_config_loader.sv */
`timescale 1ns/1ps
// What this block does
// - Power-up copies programmed settings into RAM
// - Reset subcommand reloads as at power-up
// - Settings held in normal, sleep, deep sleep
// - Shutdown clears settings, reload on return
// - Array starts zero, bits only rise
// - Loaded setting is image1^image2^default
// - Signature mismatch boots with defaults
// - Eight signature slots for reprogramming
// - Signature skips factory and failure data
// - Regulator bytes change through image two
// - Bit 7 ok, then no other bits
// - Bit 5 reports lock or missing modes
// - Bit 4 no slot, bit 3 data exhausted
// - Bits 2,1,0: hot, supply low, high
// - Bytes 1,2 give failing address lo,hi
// - Program returns same status, bit 7 done
// - Configuration programming about 200 us/byte
// - In-operation writes need field program enable
// - Factory data writable in unrestricted access
// - Failure store needs both enables, low check
// - In-operation programming about 125 ms/byte
// - Unsigned values stored little-endian
// - Busy code reads all ones, then code
module otp_config_loader #(
    parameter int FAST_CYC = otp_loader_pkg::FAST_BYTE_CYC,
    parameter int SLOW_CYC = otp_loader_pkg::SLOW_BYTE_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [6:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic full_access,
    input wire logic config_update,
    input wire logic temp_high,
    input wire logic supply_low,
    input wire logic supply_high,
    input wire logic shutdown,
    output logic [otp_loader_pkg::N_SET*8-1:0] settings,
    output logic busy,
    output logic sig_fault
);
    import otp_loader_pkg::*;

    state_t state_r, state_nxt;
    prog_kind_t kind_r;
    logic [N_SET*8-1:0] set_r, merged_w;
    logic [BUF_N*8-1:0] buf_r;
    logic [7:0] cmd_lo_r, cmd_hi_r, csum_r, len_r, rdata_r, res_w;
    logic [3:0] pidx_r, pend_w;
    logic [2:0] slot_r, next_slot, fail_idx;
    logic [15:0] sig_new_r, sig_last, code_w, code_r, fail_addr;
    logic [OTP_N*8-1:0] otp_flat;
    logic [N_SIG-1:0] slot_used;
    logic [10:0] plan_w [N_SET];
    logic sig_fault_r, sig_any, sig_ok, nodata, lock_w, otp_busy;
    logic wr_req, len_ok, data_cmd;
    logic [5:0] wr_idx;
    logic [7:0] wr_val;

    // Address window decode, shared by read and write paths
    function automatic logic in_win(input logic [6:0] a,
                                    input logic [6:0] base,
                                    input int n);
        return (7'(a - base) < 7'(n));
    endfunction : in_win

    // Rotate-xor signature over the settings bytes only
    function automatic logic [15:0] sig_f(input logic [N_SET*8-1:0] v);
        logic [15:0] s;
        s = SIG_SEED;
        for (int k = 0; k < N_SET; k++) begin
            s = {s[14:0], s[15]} ^ {8'h00, v[k*8 +: 8]};
        end
        return s;
    endfunction : sig_f

    // Window checksum: code bytes plus used buffer bytes, inverted
    function automatic logic [7:0] csum_f(input logic [7:0] lo,
                                          input logic [7:0] hi,
                                          input logic [BUF_N*8-1:0] b,
                                          input logic [7:0] len);
        logic [7:0] s;
        s = lo + hi;
        for (int i = 0; i < BUF_N; i++) begin
            if (8'(i) + LEN_OVH < len) begin
                s = s + b[i*8 +: 8];
            end
        end
        return ~s;
    endfunction : csum_f

    // Pick the image for a changed byte: {fail, use2, need, value}
    function automatic logic [10:0] plan_f(input logic reg_byte,
                                           input logic [7:0] d,
                                           input logic [7:0] i1,
                                           input logic [7:0] i2);
        if (d == 8'h00) begin
            return 11'h000;
        end else if (!reg_byte && ((i1 & d) == 8'h00)) begin
            return {3'b001, d};
        end else if ((i2 & d) == 8'h00) begin
            return {3'b011, d};
        end
        return {3'b100, 8'h00};
    endfunction : plan_f

    otp_array #(
        .FAST_CYC(FAST_CYC),
        .SLOW_CYC(SLOW_CYC)
    ) u_otp (
        .clk(clk),
        .rst_n(rst_n),
        .wr_req(wr_req),
        .wr_idx(wr_idx),
        .wr_data(wr_val),
        .slow(kind_r != PK_CFG),
        .busy(otp_busy),
        .flat(otp_flat)
    );

    // Per-byte merge and programming plan
    genvar k;
    generate
        for (k = 0; k < N_SET; k++) begin : g_set
            logic [7:0] i1, i2, df;
            assign i1 = otp_flat[(O_IMG1 + k)*8 +: 8];
            assign i2 = otp_flat[(O_IMG2 + k)*8 +: 8];
            assign df = SET_DEF[k*8 +: 8];
            assign merged_w[k*8 +: 8] = i1 ^ i2 ^ df;
            // Regulator bytes carry factory bits in image one
            assign plan_w[k] = plan_f((k == S_AUX_REGULATOR_ONE) || (k == S_AUX_REGULATOR_ZERO),
                set_r[k*8 +: 8] ^ df ^ i1 ^ i2, i1, i2);
        end
        for (k = 0; k < N_SIG; k++) begin : g_slot
            assign slot_used[k] = |otp_flat[(O_SIG + 2*k)*8 +: 16];
        end
    endgenerate

    // Latest written slot holds the live signature
    always_comb begin
        sig_any = 1'b0;
        sig_last = 16'h0000;
        next_slot = 3'h0;
        for (int j = 0; j < N_SIG; j++) begin
            if (slot_used[j]) begin
                sig_any = 1'b1;
                sig_last = otp_flat[(O_SIG + 2*j)*8 +: 16];
                next_slot = 3'(j + 1);
            end
        end
    end

    // Factory and failure bytes stay outside the signature
    assign sig_ok = sig_any && (sig_last == sig_f(merged_w));

    // First byte that no image can still absorb
    always_comb begin
        nodata = 1'b0;
        fail_idx = 3'h0;
        for (int j = N_SET - 1; j >= 0; j--) begin
            if (plan_w[j][10]) begin
                nodata = 1'b1;
                fail_idx = 3'(j);
            end
        end
    end
    assign fail_addr = {9'h000, A_SET + {4'h0, fail_idx}};

    // Self-check status byte; the host owns the mode setup
    assign lock_w = !(full_access && config_update) ||
                    (otp_flat[O_LOCK*8 +: 8] != 8'h00);
    always_comb begin
        res_w = 8'h00;
        res_w[B_LOCK] = lock_w;
        res_w[B_NOSIG] = slot_used[N_SIG-1];
        res_w[B_NODATA] = nodata;
        res_w[B_TEMP] = temp_high;
        res_w[B_LOW] = supply_low;
        res_w[B_HIGH] = supply_high;
        res_w[B_OK] = ~|res_w;
    end

    // Subcommand decode; code is whole once the high byte lands
    assign code_w = {wdata, cmd_lo_r};
    assign code_r = {cmd_hi_r, cmd_lo_r};
    assign data_cmd = (code_w == SC_CHECK) || (code_w == SC_WRITE) ||
                      (code_w == SC_FACTORY) || (code_w == SC_FAIL);
    assign busy = (state_r == ST_EXEC) || (state_r == ST_PROG) ||
                  (state_r == ST_DONE);

    // In-operation writes; max supply limit waived here
    assign len_ok = (csum_f(cmd_lo_r, cmd_hi_r, buf_r, wdata) == csum_r) &&
        set_r[S_MFG_INIT*8 + F_PROG_EN] && !supply_low &&
        (((code_r == SC_FACTORY) && full_access &&
          (wdata == LEN_FACT)) ||
         ((code_r == SC_FAIL) && set_r[S_PROT*8 + F_FAIL_EN] &&
          (wdata == LEN_FAIL)));

    // Sequencer
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_OFF: if (!shutdown) state_nxt = ST_LOAD;
            ST_LOAD: state_nxt = ST_RUN;
            ST_RUN: begin
                if (wr && (addr == A_CMD_HI)) begin
                    if (code_w == SC_RESET) begin
                        state_nxt = ST_LOAD;
                    end else if (data_cmd) begin
                        state_nxt = ST_EXEC;
                    end
                end else if (wr && (addr == A_LEN) && len_ok) begin
                    state_nxt = ST_PROG;
                end
            end
            ST_EXEC: begin
                // Failed check leaves the array untouched
                if ((code_r == SC_WRITE) && res_w[B_OK]) begin
                    state_nxt = ST_PROG;
                end else begin
                    state_nxt = ST_DONE;
                end
            end
            ST_PROG: if (!otp_busy && (pidx_r == pend_w)) state_nxt = ST_DONE;
            ST_DONE: state_nxt = ST_RUN;
            default: state_nxt = ST_LOAD;
        endcase
        if (shutdown) state_nxt = ST_OFF;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) state_r <= ST_LOAD;
        else state_r <= state_nxt;
    end

    // Programming item for the current step
    assign pend_w = (kind_r == PK_CFG) ? PEND_CFG :
                    (kind_r == PK_FACT) ? PEND_FACT : PEND_FAIL;
    always_comb begin
        wr_req = 1'b0;
        wr_idx = 6'h00;
        wr_val = 8'h00;
        if ((state_r == ST_PROG) && !otp_busy && (pidx_r != pend_w)) begin
            if (kind_r == PK_FACT) begin
                wr_req = 1'b1;
                wr_idx = O_FACT + {2'b00, pidx_r};
                wr_val = buf_r[pidx_r[0]*8 +: 8];
            end else if (kind_r == PK_FAIL) begin
                wr_req = 1'b1;
                wr_idx = O_FAIL;
                wr_val = buf_r[7:0];
            end else if (pidx_r < 4'(N_SET)) begin
                wr_req = plan_w[pidx_r[2:0]][8];
                wr_idx = (plan_w[pidx_r[2:0]][9] ? O_IMG2 : O_IMG1) +
                         {3'b000, pidx_r[2:0]};
                wr_val = plan_w[pidx_r[2:0]][7:0];
            end else begin
                // New signature into the next free slot, low byte first
                wr_req = 1'b1;
                wr_idx = O_SIG + {2'b00, slot_r, 1'b0} +
                         {5'h00, pidx_r[0]};
                wr_val = pidx_r[0] ? sig_new_r[15:8] : sig_new_r[7:0];
            end
        end
    end

    // Step counter; unchanged bytes cost one cycle, written ones a timer
    always_ff @(posedge clk) begin
        if (!rst_n || (state_r != ST_PROG)) begin
            pidx_r <= 4'h0;
        end else if (!otp_busy && (pidx_r != pend_w)) begin
            pidx_r <= pidx_r + 4'h1;
        end
    end

    // Settings RAM: only reset, load, shutdown or a bus write change it
    always_ff @(posedge clk) begin
        if (!rst_n || shutdown || (state_r == ST_OFF)) begin
            set_r <= '0;
        end else if (state_r == ST_LOAD) begin
            set_r <= sig_ok ? merged_w : SET_DEF;
        end else if (state_r == ST_RUN && wr && config_update &&
                     in_win(addr, A_SET, N_SET)) begin
            set_r[3'(addr - A_SET)*8 +: 8] <= wdata;
        end
    end
    assign settings = set_r;

    always_ff @(posedge clk) begin
        if (!rst_n) sig_fault_r <= 1'b0;
        else if (state_r == ST_LOAD) sig_fault_r <= sig_any && !sig_ok;
    end
    assign sig_fault = sig_fault_r;

    // Command pair; reset subcommand clears it with the reload
    always_ff @(posedge clk) begin
        if (!rst_n || (state_r == ST_LOAD)) begin
            cmd_lo_r <= 8'h00;
            cmd_hi_r <= 8'h00;
        end else if (state_r == ST_RUN && wr && addr == A_CMD_LO) begin
            cmd_lo_r <= wdata;
        end else if (state_r == ST_RUN && wr && addr == A_CMD_HI) begin
            cmd_hi_r <= wdata;
        end
    end

    // Transfer buffer: host data or subcommand answer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            buf_r <= '0;
        end else if (state_r == ST_RUN && wr && in_win(addr, A_BUF, BUF_N)) begin
            buf_r[2'(addr - A_BUF)*8 +: 8] <= wdata;
        end else if (state_r == ST_EXEC) begin
            if (code_r == SC_FACTORY) begin
                buf_r <= {16'h0000, otp_flat[O_FACT*8 +: 16]};
            end else if (code_r == SC_FAIL) begin
                buf_r <= {24'h000000, otp_flat[O_FAIL*8 +: 8]};
            end else begin
                // Address follows only when data ran out
                buf_r <= {8'h00, nodata ? fail_addr : 16'h0000,
                          res_w};
            end
        end
    end

    // Length, checksum, slot and signature captured for the pass
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            len_r <= 8'h00;
            csum_r <= 8'h00;
            slot_r <= 3'h0;
            sig_new_r <= 16'h0000;
        end else if (state_r == ST_RUN && wr && addr == A_LEN) begin
            len_r <= wdata;
        end else if (state_r == ST_RUN && wr && addr == A_CSUM) begin
            csum_r <= wdata;
        end else if (state_r == ST_EXEC) begin
            len_r <= (code_r == SC_FACTORY) ? LEN_FACT :
                     (code_r == SC_FAIL) ? LEN_FAIL : LEN_RES;
            slot_r <= next_slot;
            sig_new_r <= sig_f(set_r);
        end else if (state_r == ST_DONE) begin
            csum_r <= csum_f(cmd_lo_r, cmd_hi_r, buf_r, len_r);
        end
    end

    // Kind of programming pass, fixed when it starts
    always_ff @(posedge clk) begin
        if (!rst_n) kind_r <= PK_CFG;
        else if (state_r == ST_EXEC) kind_r <= PK_CFG;
        else if (state_r == ST_RUN && wr && addr == A_LEN) begin
            kind_r <= (code_r == SC_FAIL) ? PK_FAIL : PK_FACT;
        end
    end

    // Read path; busy hides the code so polling sees all ones
    always_ff @(posedge clk) begin
        if (!rst_n || !rd) begin
            rdata_r <= 8'h00;
        end else if (addr == A_CMD_LO) begin
            rdata_r <= busy ? 8'hff : cmd_lo_r;
        end else if (addr == A_CMD_HI) begin
            rdata_r <= busy ? 8'hff : cmd_hi_r;
        end else if (in_win(addr, A_BUF, BUF_N)) begin
            rdata_r <= buf_r[2'(addr - A_BUF)*8 +: 8];
        end else if (addr == A_CSUM) begin
            rdata_r <= csum_r;
        end else if (addr == A_LEN) begin
            rdata_r <= len_r;
        end else if (in_win(addr, A_SET, N_SET)) begin
            rdata_r <= set_r[3'(addr - A_SET)*8 +: 8];
        end else begin
            rdata_r <= 8'h00;
        end
    end
    assign rdata = rdata_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence reload_s;
        state_r == ST_LOAD ##1 state_r == ST_RUN;
    endsequence

    chk_load_merge: assert property (
        state_r == ST_LOAD && sig_ok && !shutdown
        |=> settings == $past(merged_w))
        else $error("loaded settings differ from image merge");
    chk_sig_default: assert property (
        state_r == ST_LOAD && !sig_ok && !shutdown |=> settings == SET_DEF)
        else $error("bad signature did not boot defaults");
    chk_reset_cmd: assert property (
        state_r == ST_RUN && wr && addr == A_CMD_HI &&
        code_w == SC_RESET && !shutdown ##1 !shutdown |-> reload_s)
        else $error("reset subcommand did not reload");
    chk_shutdown_clear: assert property (
        shutdown |=> settings == '0)
        else $error("shutdown left settings in place");
    chk_retain_run: assert property (
        state_r == ST_RUN && !shutdown && !(wr && in_win(addr, A_SET, N_SET))
        |=> $stable(settings))
        else $error("settings changed without a write");
    chk_ok_alone: assert property (
        state_r == ST_EXEC && code_r == SC_CHECK && res_w[B_OK] && !shutdown
        |=> buf_r[7:0] == 8'h80)
        else $error("ok status carries other bits");
    chk_busy_ones: assert property (
        busy && rd && addr == A_CMD_LO |=> rdata == 8'hff)
        else $error("busy code readback not all ones");
    chk_bits_rise: assert property (
        ((~otp_flat) & $past(otp_flat)) == '0)
        else $error("programmed bit returned to zero");
    chk_no_prog_err: assert property (
        state_r == ST_EXEC && code_r == SC_WRITE && !res_w[B_OK] &&
        !shutdown |=> state_r == ST_DONE ##1 !$changed(otp_flat))
        else $error("array changed after a failed check");
endmodule : otp_config_loader

/* hdl/otp_loader_pkg.sv */
package otp_loader_pkg;
    // Register window, 7-bit command space
    localparam logic [6:0] A_SET = 7'h00;
    localparam logic [6:0] A_CMD_LO = 7'h3e;
    localparam logic [6:0] A_CMD_HI = 7'h3f;
    localparam logic [6:0] A_BUF = 7'h40;
    localparam logic [6:0] A_CSUM = 7'h60;
    localparam logic [6:0] A_LEN = 7'h61;
    localparam int N_SET = 8;
    localparam int BUF_N = 4;

    // Subcommand codes
    localparam logic [15:0] SC_RESET = 16'h0012;
    localparam logic [15:0] SC_CHECK = 16'h00a0;
    localparam logic [15:0] SC_WRITE = 16'h00a1;
    localparam logic [15:0] SC_FACTORY = 16'h0070;
    localparam logic [15:0] SC_FAIL = 16'h0053;

    // Programmable array byte map
    localparam int OTP_N = 36;
    localparam logic [5:0] O_IMG1 = 6'h00;
    localparam logic [5:0] O_IMG2 = 6'h08;
    localparam logic [5:0] O_SIG = 6'h10;
    localparam int N_SIG = 8;
    localparam logic [5:0] O_LOCK = 6'h20;
    localparam logic [5:0] O_FACT = 6'h21;
    localparam int FACT_N = 2;
    localparam logic [5:0] O_FAIL = 6'h23;

    // Self-check result byte 0
    localparam int B_OK = 7;
    localparam int B_LOCK = 5;
    localparam int B_NOSIG = 4;
    localparam int B_NODATA = 3;
    localparam int B_TEMP = 2;
    localparam int B_LOW = 1;
    localparam int B_HIGH = 0;

    // Settings bytes that steer the loader
    localparam int S_MFG_INIT = 4;
    localparam int S_PROT = 5;
    localparam int S_AUX_REGULATOR_ONE = 6;
    localparam int S_AUX_REGULATOR_ZERO = 7;
    localparam int F_PROG_EN = 0;
    localparam int F_FAIL_EN = 0;
    localparam logic [63:0] SET_DEF = 64'h0000_0000_0000_0000;
    localparam logic [15:0] SIG_SEED = 16'h1d0f;

    // Answer lengths: payload plus four window bytes
    localparam logic [7:0] LEN_OVH = 8'h04;
    localparam logic [7:0] LEN_RES = 8'h07;
    localparam logic [7:0] LEN_FACT = 8'h06;
    localparam logic [7:0] LEN_FAIL = 8'h05;
    localparam logic [3:0] PEND_CFG = 4'ha;
    localparam logic [3:0] PEND_FACT = 4'h2;
    localparam logic [3:0] PEND_FAIL = 4'h1;

    // Byte programming times
    localparam int CLK_PERIOD_NS = 8;
    localparam int FAST_BYTE_NS = 200_000;
    localparam int SLOW_BYTE_MS = 125;
    localparam int FAST_BYTE_CYC = FAST_BYTE_NS / CLK_PERIOD_NS;
    localparam int SLOW_BYTE_CYC = SLOW_BYTE_MS * 1_000_000 / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_OFF, ST_LOAD, ST_RUN, ST_EXEC, ST_PROG, ST_DONE
    } state_t;
    typedef enum logic [1:0] {PK_CFG, PK_FACT, PK_FAIL} prog_kind_t;
endpackage : otp_loader_pkg

/* hdl/otp_array.sv */
`timescale 1ns/1ps
module otp_array #(
    parameter int FAST_CYC = otp_loader_pkg::FAST_BYTE_CYC,
    parameter int SLOW_CYC = otp_loader_pkg::SLOW_BYTE_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_req,
    input wire logic [5:0] wr_idx,
    input wire logic [7:0] wr_data,
    input wire logic slow,
    output logic busy,
    output logic [otp_loader_pkg::OTP_N*8-1:0] flat
);
    import otp_loader_pkg::*;

    // Blank part reads all zeros; reset never clears the array
    logic [7:0] mem [OTP_N] = '{default: 8'h00};
    logic [23:0] cnt_r;
    logic take;

    assign take = wr_req && (cnt_r == 24'h0);
    assign busy = (cnt_r != 24'h0);

    // Byte timer, slow rate for in-operation writes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_r <= 24'h0;
        end else if (take) begin
            cnt_r <= slow ? 24'(SLOW_CYC) : 24'(FAST_CYC);
        end else if (busy) begin
            cnt_r <= cnt_r - 24'h1;
        end
    end

    // Bits can only be raised, never lowered
    always_ff @(posedge clk) begin
        if (take && (wr_idx < 6'(OTP_N))) begin
            mem[wr_idx] <= mem[wr_idx] | wr_data;
        end
    end

    genvar g;
    generate
        for (g = 0; g < OTP_N; g++) begin : g_flat
            assign flat[g*8 +: 8] = mem[g];
        end
    endgenerate
endmodule : otp_array

/* testbench/host_bus.sv */
`timescale 1ns/1ps
// Host model: one strobe at a time, changed just after the edge
module host_bus (
    input wire logic clk,
    output logic [6:0] addr,
    output logic [7:0] wdata,
    output logic wr,
    output logic rd,
    input wire logic [7:0] rdata
);
    initial begin
        addr = 7'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end
    // Single write cycle, address scrambled once released
    task automatic put(input logic [6:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~v;
    endtask : put
    // Read data stands only in the cycle after the strobe
    task automatic get(input logic [6:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : get
    // Low byte first, the high byte launches the subcommand
    task automatic send(input logic [15:0] code);
        put(7'h3e, code[7:0]);
        put(7'h3f, code[15:8]);
    endtask : send
endmodule : host_bus

/* testbench/test_otp_config_loader.sv */
`timescale 1ns/1ps
module test_otp_config_loader;
    import otp_loader_pkg::*;
    logic clk, rst_n, fa, cu, th, sl, sh, sd, wr, rd, busy, sig_fault;
    logic [6:0] addr;
    logic [7:0] wdata, rdata, v, cw;
    logic [63:0] settings;
    int fail_count = 0;
    int n_tests = 0;
    int seed = 30045;
    int exp_set[8];
    int fb;
    // Short byte times keep programming runs brief
    otp_config_loader #(.FAST_CYC(4), .SLOW_CYC(8)) i_otp_config_loader (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .full_access(fa), .config_update(cu),
        .temp_high(th), .supply_low(sl), .supply_high(sh), .shutdown(sd),
        .settings(settings), .busy(busy), .sig_fault(sig_fault));
    host_bus i_host_bus (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        n_tests++;
        if (seen !== want) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask : check
    task automatic complete_run();
        if (fail_count == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run
    // Reference copy of the settings bytes
    function automatic logic [63:0] model_vec();
        logic [63:0] r;
        for (int k = 0; k < 8; k++)
            r[k*8 +: 8] = exp_set[k][7:0];
        return r;
    endfunction : model_vec
    // Random settings through the register port
    task automatic load_set();
        for (int k = 0; k < 8; k++) begin
            exp_set[k] = $random(seed) & 255;
            i_host_bus.put(k[6:0], exp_set[k][7:0]);
        end
        // Last write lands on this edge; look one edge later
        @(posedge clk);
        check(settings, model_vec());
    endtask : load_set
    // Poll the low code byte until the subcommand has finished
    task automatic poll(input logic [7:0] lo);
        int n;
        n = 0;
        #1 check(busy, 1'b1);
        i_host_bus.get(A_CMD_LO, v);
        check(v, 8'hff);
        while (v !== lo && n < 500) begin
            i_host_bus.get(A_CMD_LO, v);
            n++;
        end
        if (n == 500) begin
            fail_count++;
            complete_run();
        end
        check(v, lo);
        check(busy, 1'b0);
    endtask : poll
    // Issue a data subcommand, poll, then read the whole answer
    task automatic answer(input logic [15:0] code, input logic [31:0] eb,
                          input logic [7:0] len);
        logic [7:0] cs;
        cs = code[7:0] + code[15:8];
        // Checksum covers only the used buffer bytes
        for (int i = 0; i < 4; i++)
            if (i + 4 < len) cs = cs + eb[i*8 +: 8];
        cs = ~cs;
        i_host_bus.send(code);
        poll(code[7:0]);
        for (int i = 0; i < 4; i++) begin
            i_host_bus.get(A_BUF + 7'(i), v);
            check(v, eb[i*8 +: 8]);
        end
        i_host_bus.get(A_CSUM, v);
        check(v, cs);
        i_host_bus.get(A_LEN, v);
        check(v, len);
    endtask : answer
    // Reset subcommand, then let the reload finish
    task automatic reload();
        i_host_bus.send(SC_RESET);
        repeat (6) @(posedge clk);
    endtask : reload
    initial begin
        rst_n = 1'b0;
        fa = 1'b0;
        cu = 1'b1;
        th = 1'b0;
        sl = 1'b0;
        sh = 1'b0;
        sd = 1'b0;
        for (int k = 0; k < 8; k++)
            exp_set[k] = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        check(settings, model_vec());
        // Locked program attempt must leave the array blank
        load_set();
        answer(SC_WRITE, 32'h20, LEN_RES);
        for (int k = 0; k < 8; k++)
            exp_set[k] = 0;
        reload();
        check(settings, model_vec());
        // Modes first, then the hot, supply low and supply high conditions in turn
        fa <= 1'b1;
        load_set();
        for (int k = 0; k < 4; k++) begin
            th <= (k == 0);
            sl <= (k == 1);
            sh <= (k == 2);
            fb = (k == 3) ? 'h80 : 'h04 >> k;
            answer(SC_CHECK, fb, LEN_RES);
        end
        answer(SC_WRITE, 32'h80, LEN_RES);
        for (int k = 0; k < 8; k++)
            i_host_bus.put(k[6:0], 8'h00);
        reload();
        check(settings, model_vec());
        check(sig_fault, 1'b0);
        repeat (20) @(posedge clk);
        check(settings, model_vec());
        // Shutdown clears, power return reloads programmed image
        sd <= 1'b1;
        repeat (3) @(posedge clk);
        check(settings, 64'h0);
        sd <= 1'b0;
        repeat (6) @(posedge clk);
        check(settings, model_vec());
        // In-operation factory write; high supply must not block it
        exp_set[4] = exp_set[4] | 1;
        i_host_bus.put(7'(S_MFG_INIT), exp_set[4][7:0]);
        sh <= 1'b1;
        answer(SC_FACTORY, 32'h0, LEN_FACT);
        fb = $random(seed) & 'hffff;
        cw = ~(SC_FACTORY[7:0] + SC_FACTORY[15:8] + fb[7:0] + fb[15:8]);
        i_host_bus.put(A_BUF, fb[7:0]);
        i_host_bus.put(A_BUF + 7'h01, fb[15:8]);
        i_host_bus.put(A_CSUM, cw);
        i_host_bus.put(A_LEN, LEN_FACT);
        poll(SC_FACTORY[7:0]);
        answer(SC_FACTORY, fb, LEN_FACT);
        sh <= 1'b0;
        complete_run();
    end
endmodule : test_otp_config_loader
